//--- rtl/iwd_map.svh
// Purpose: Constants of the two-wire register port and its watchdog.
// Assumes: 100 MHz core clock.
// Notes:   Offsets, reset values and timing counts only.
`ifndef IWD_MAP_SVH
`define IWD_MAP_SVH

// ----------------------------------------
// Addressing
// ----------------------------------------
`define IWD_ADDR_BASE 7'h50
`define IWD_REG_COUNT 32

// ----------------------------------------
// Termination control
// ----------------------------------------
`define IWD_ROLE_OPEN 4'hF
`define IWD_ROLE_RST 4'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define IWD_CLK_MHZ 100
`define IWD_FILT_LEN 2
`define IWD_WD_T0_US 1000
`define IWD_WD_T1_US 2000
`define IWD_WD_T2_US 5000
`define IWD_WD_T3_US 10000
`define IWD_WD_CNT_W 24

`endif

//--- rtl/iwd_pkg.sv
// Purpose: Shared types of the two-wire register port.
// Assumes: Nothing beyond the map header.
// Notes:   Types only; constants live in iwd_map.svh.
package iwd_pkg;

   // ----------------------------------------
   // Byte engine states and byte kinds
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RX,
      ST_ACK,
      ST_TX,
      ST_TXACK,
      ST_IGN
   } iwd_state_type;

   typedef enum logic [1:0] {
      K_ADDR,
      K_IDX,
      K_DATA
   } iwd_kind_type;

endpackage : iwd_pkg

//--- rtl/iwd_sync.sv
// Purpose: Three-stage synchroniser with glitch filter for one pin.
// Assumes: Pin is asynchronous to i_core_clk.
// Notes:   Output moves once stages two and three agree for FILT_LEN cycles.
`timescale 1ns/1ns
`include "iwd_map.svh"
module iwd_sync #(
   parameter int FILT_LEN = `IWD_FILT_LEN,
   parameter logic RST_VAL = 1'b1
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_reset,
   // Pin and filtered level
   input wire logic i_pin,
   output logic o_level
);
   typedef struct packed {
      logic ff1;
      logic ff2;
      logic ff3;
      logic level;
      logic [7:0] cnt;
   } iwd_sync_type;

   iwd_sync_type r;
   iwd_sync_type n;
   localparam logic [7:0] LAST = 8'(FILT_LEN - 1);

   always_comb begin
      n = r;
      n.ff1 = i_pin;
      n.ff2 = r.ff1;
      n.ff3 = r.ff2;
      if (r.ff2 == r.ff3 && r.ff3 != r.level) begin
         if (r.cnt >= LAST) begin
            n.level = r.ff3;
            n.cnt = 8'h00;
         end else begin
            n.cnt = r.cnt + 8'h01;
         end
      end else begin
         n.cnt = 8'h00;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         r <= '{ff1: RST_VAL, ff2: RST_VAL, ff3: RST_VAL, level: RST_VAL, cnt: 8'h00};
      end else begin
         r <= n;
      end
   end

   assign o_level = r.level;

endmodule : iwd_sync

//--- rtl/iwd_top.sv
// Purpose: Two-wire target register port with communication watchdog.
// Assumes: Host drives SCL; SCL and SDA are asynchronous pins.
// Notes:   Register file is flip-flops; indices beyond it read zero.
`timescale 1ns/1ns
`include "iwd_map.svh"
module iwd_top #(
   parameter int REG_COUNT = `IWD_REG_COUNT,
   parameter int FILT_LEN = `IWD_FILT_LEN,
   parameter int WD_CYC0 = `IWD_WD_T0_US * `IWD_CLK_MHZ,
   parameter int WD_CYC1 = `IWD_WD_T1_US * `IWD_CLK_MHZ,
   parameter int WD_CYC2 = `IWD_WD_T2_US * `IWD_CLK_MHZ,
   parameter int WD_CYC3 = `IWD_WD_T3_US * `IWD_CLK_MHZ
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_reset,
   // Two-wire pins
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_out,
   output logic o_sda_oe,
   // Strap and enable
   input wire logic i_enable,
   input wire logic [1:0] i_addr_sel,
   // Alert
   input wire logic [7:0] i_alert_flags,
   input wire logic [7:0] i_alert_mask,
   output logic o_alert_n_out,
   output logic o_alert_n_oe,
   // Watchdog control
   input wire logic i_wdog_enable_bit,
   input wire logic [1:0] i_wdog_period_sel,
   // Termination and VBUS
   input wire logic i_role_wr,
   input wire logic [3:0] i_role_wdata,
   output logic [3:0] o_termination_role_ctrl,
   input wire logic i_vbus_above_safe0,
   output logic o_vbus_discharge,
   output logic o_host_link_err,
   input wire logic i_host_link_err_clr,
   // Register write notice
   output logic o_wr_pulse,
   output logic [7:0] o_wr_index,
   output logic [7:0] o_wr_data,
   output logic o_host_access
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      iwd_pkg::iwd_state_type state;
      iwd_pkg::iwd_kind_type kind;
      logic [3:0] bitcnt;
      logic [7:0] shreg;
      logic [7:0] ptr;
      logic rd;
      logic host_ack;
      logic sda_oe;
      logic scl_prev;
      logic sda_prev;
      logic enable_prev;
      logic [6:0] dev_addr;
      logic alert;
      logic wr_pulse;
      logic [7:0] wr_index;
      logic [7:0] wr_data;
      logic access;
      logic [REG_COUNT-1:0][7:0] mem;
   } iwd_core_type;
   iwd_core_type r;
   iwd_core_type n;
   function automatic logic [7:0] fetch(input logic [REG_COUNT-1:0][7:0] m,
                                        input logic [7:0] idx);
      fetch = (int'(idx) < REG_COUNT) ? m[idx] : 8'h00;
   endfunction : fetch
   // ----------------------------------------
   // Pin conditioning
   // ----------------------------------------
   logic [2:0] pins;
   logic [2:0] levels;
   logic scl_s;
   logic sda_s;
   logic vbus_s;
   assign pins = {i_vbus_above_safe0, i_sda, i_scl};
   for (genvar g = 0; g < 3; g++) begin : g_sync
      iwd_sync #(
         .FILT_LEN(FILT_LEN),
         .RST_VAL(1'b1)
      ) u_sync (
         .i_core_clk(i_core_clk),
         .i_reset(i_reset),
         .i_pin(pins[g]),
         .o_level(levels[g])
      );
   end
   assign scl_s = levels[0];
   assign sda_s = levels[1];
   assign vbus_s = levels[2];
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic [7:0] rd_byte;
   assign scl_rise = scl_s && !r.scl_prev;
   assign scl_fall = !scl_s && r.scl_prev;
   assign start_det = scl_s && r.scl_prev && r.sda_prev && !sda_s;
   assign stop_det = scl_s && r.scl_prev && !r.sda_prev && sda_s;
   assign rd_byte = fetch(r.mem, r.ptr);

   // ----------------------------------------
   // Byte engine
   // ----------------------------------------
   always_comb begin
      n = r;
      n.scl_prev = scl_s;
      n.sda_prev = sda_s;
      n.enable_prev = i_enable;
      n.wr_pulse = 1'b0;
      n.access = 1'b0;
      n.alert = |(i_alert_flags & i_alert_mask);
      if (i_enable && !r.enable_prev) begin
         n.dev_addr = `IWD_ADDR_BASE + {5'h00, i_addr_sel};
      end
      if (stop_det) begin
         n.state = iwd_pkg::ST_IDLE;
         n.sda_oe = 1'b0;
      end else if (start_det) begin
         n.state = iwd_pkg::ST_RX;
         n.kind = iwd_pkg::K_ADDR;
         n.bitcnt = 4'h0;
         n.sda_oe = 1'b0;
      end else begin
         unique case (r.state)
            iwd_pkg::ST_IDLE, iwd_pkg::ST_IGN: begin
               n.sda_oe = 1'b0;
            end
            iwd_pkg::ST_RX: begin
               if (scl_rise && r.bitcnt != 4'h8) begin
                  n.shreg = {r.shreg[6:0], sda_s};
                  n.bitcnt = r.bitcnt + 4'h1;
               end else if (scl_fall && r.bitcnt == 4'h8) begin
                  n.state = iwd_pkg::ST_ACK;
                  n.sda_oe = 1'b1;
                  unique case (r.kind)
                     iwd_pkg::K_ADDR: begin
                        // General call never matches an address in 0x50..0x53
                        if (r.shreg[7:1] == r.dev_addr) begin
                           n.rd = r.shreg[0];
                           n.access = 1'b1;
                        end else begin
                           n.state = iwd_pkg::ST_IGN;
                           n.sda_oe = 1'b0;
                        end
                     end
                     iwd_pkg::K_IDX: begin
                        n.ptr = r.shreg;
                     end
                     iwd_pkg::K_DATA: begin
                        n.wr_pulse = 1'b1;
                        n.wr_index = r.ptr;
                        n.wr_data = r.shreg;
                        if (int'(r.ptr) < REG_COUNT) begin
                           n.mem[r.ptr] = r.shreg;
                        end
                     end
                     default: begin
                        n.state = iwd_pkg::ST_IGN;
                        n.sda_oe = 1'b0;
                     end
                  endcase
               end
            end
            iwd_pkg::ST_ACK: begin
               if (scl_fall) begin
                  n.sda_oe = 1'b0;
                  n.bitcnt = 4'h0;
                  n.state = iwd_pkg::ST_RX;
                  if (r.kind == iwd_pkg::K_ADDR && r.rd) begin
                     n.state = iwd_pkg::ST_TX;
                     n.shreg = rd_byte;
                     n.sda_oe = ~rd_byte[7];
                  end else if (r.kind == iwd_pkg::K_ADDR) begin
                     n.kind = iwd_pkg::K_IDX;
                  end else begin
                     n.kind = iwd_pkg::K_DATA;
                     if (r.kind == iwd_pkg::K_DATA) begin
                        n.ptr = r.ptr + 8'h01;
                     end
                  end
               end
            end
            iwd_pkg::ST_TX: begin
               if (scl_fall) begin
                  if (r.bitcnt == 4'h7) begin
                     n.sda_oe = 1'b0;
                     n.state = iwd_pkg::ST_TXACK;
                     n.host_ack = 1'b0;
                     n.ptr = r.ptr + 8'h01;
                  end else begin
                     n.bitcnt = r.bitcnt + 4'h1;
                     n.shreg = {r.shreg[6:0], 1'b0};
                     n.sda_oe = ~r.shreg[6];
                  end
               end
            end
            iwd_pkg::ST_TXACK: begin
               if (scl_rise) begin
                  if (sda_s) begin
                     n.state = iwd_pkg::ST_IGN;
                  end else begin
                     n.host_ack = 1'b1;
                  end
               end else if (scl_fall && r.host_ack) begin
                  n.state = iwd_pkg::ST_TX;
                  n.bitcnt = 4'h0;
                  n.shreg = rd_byte;
                  n.sda_oe = ~rd_byte[7];
               end
            end
            default: begin
               n.state = iwd_pkg::ST_IDLE;
               n.sda_oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         r <= '0;
         r.dev_addr <= `IWD_ADDR_BASE;
         r.scl_prev <= 1'b1;
         r.sda_prev <= 1'b1;
      end else begin
         r <= n;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // SCL is input only: no stretching, so replies land within one SCL phase
   assign o_sda_out = 1'b0;
   assign o_sda_oe = r.sda_oe;
   assign o_alert_n_out = 1'b0;
   assign o_alert_n_oe = r.alert;
   assign o_wr_pulse = r.wr_pulse;
   assign o_wr_index = r.wr_index;
   assign o_wr_data = r.wr_data;
   assign o_host_access = r.access;

   iwd_wdog #(
      .CNT_W(`IWD_WD_CNT_W),
      .CYC0(`IWD_WD_CNT_W'(WD_CYC0)),
      .CYC1(`IWD_WD_CNT_W'(WD_CYC1)),
      .CYC2(`IWD_WD_CNT_W'(WD_CYC2)),
      .CYC3(`IWD_WD_CNT_W'(WD_CYC3))
   ) u_wdog (
      .i_core_clk(i_core_clk),
      .i_reset(i_reset),
      .i_wdog_enable_bit(i_wdog_enable_bit),
      .i_wdog_period_sel(i_wdog_period_sel),
      .i_alert_on(r.alert),
      .i_access(r.access),
      .i_role_wr(i_role_wr),
      .i_role_wdata(i_role_wdata),
      .i_vbus_above(vbus_s),
      .i_err_clr(i_host_link_err_clr),
      .o_role(o_termination_role_ctrl),
      .o_discharge(o_vbus_discharge),
      .o_err(o_host_link_err)
   );

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_reset);
   sequence byte_in_s;
      r.state == iwd_pkg::ST_RX && scl_fall && r.bitcnt == 4'h8;
   endsequence
   sequence last_bit_s;
      r.state == iwd_pkg::ST_TX && scl_fall && r.bitcnt == 4'h7;
   endsequence
   addr_ack_a: assert property (
      byte_in_s and (r.kind == iwd_pkg::K_ADDR && r.shreg[7:1] == r.dev_addr)
      |=> o_sda_oe && o_host_access)
      else $error("own address not acknowledged");
   gen_call_a: assert property (
      byte_in_s and (r.kind == iwd_pkg::K_ADDR && r.shreg == 8'h00) |=> !o_sda_oe)
      else $error("general call acknowledged");
   data_store_a: assert property (
      byte_in_s and (r.kind == iwd_pkg::K_DATA)
      |=> o_wr_pulse && o_wr_data == $past(r.shreg) && o_wr_index == $past(r.ptr))
      else $error("received data byte not stored");
   tx_release_a: assert property (last_bit_s |=> !o_sda_oe)
      else $error("SDA not released for host acknowledge");
   ptr_step_a: assert property (last_bit_s |=> r.ptr == $past(r.ptr) + 8'h01)
      else $error("read pointer did not advance");
   msb_first_a: assert property (
      r.state == iwd_pkg::ST_ACK && scl_fall && r.kind == iwd_pkg::K_ADDR && r.rd
      |=> o_sda_oe == ~$past(rd_byte[7]))
      else $error("first read bit is not the top bit");
   host_nack_a: assert property (
      r.state == iwd_pkg::ST_TXACK && scl_rise && sda_s && !stop_det && !start_det
      |=> r.state == iwd_pkg::ST_IGN ##1 !o_sda_oe)
      else $error("read continued after host refusal");
   alert_mask_a: assert property (
      (i_alert_flags & i_alert_mask) == 8'h00 |=> !o_alert_n_oe)
      else $error("alert asserted by masked flag");

endmodule : iwd_top

//--- rtl/iwd_wdog.sv
// Purpose: Communication watchdog with termination open and VBUS discharge.
// Assumes: Alert level and access pulse come from the same clock domain.
// Notes:   Expiry sequence takes three edges: role, discharge, fault.
`timescale 1ns/1ns
`include "iwd_map.svh"
module iwd_wdog #(
   parameter int CNT_W = `IWD_WD_CNT_W,
   parameter logic [CNT_W-1:0] CYC0 = CNT_W'(`IWD_WD_T0_US * `IWD_CLK_MHZ),
   parameter logic [CNT_W-1:0] CYC1 = CNT_W'(`IWD_WD_T1_US * `IWD_CLK_MHZ),
   parameter logic [CNT_W-1:0] CYC2 = CNT_W'(`IWD_WD_T2_US * `IWD_CLK_MHZ),
   parameter logic [CNT_W-1:0] CYC3 = CNT_W'(`IWD_WD_T3_US * `IWD_CLK_MHZ)
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_reset,
   // Control
   input wire logic i_wdog_enable_bit,
   input wire logic [1:0] i_wdog_period_sel,
   input wire logic i_alert_on,
   input wire logic i_access,
   input wire logic i_role_wr,
   input wire logic [3:0] i_role_wdata,
   input wire logic i_vbus_above,
   input wire logic i_err_clr,
   // Results
   output logic [3:0] o_role,
   output logic o_discharge,
   output logic o_err
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic [3:0] role;
      logic [1:0] stage;
      logic discharge;
      logic err;
      logic vbus_prev;
   } iwd_wdog_type;

   iwd_wdog_type r;
   iwd_wdog_type n;
   logic [CNT_W-1:0] limit;
   logic counting;
   logic expire;

   always_comb begin
      unique case (i_wdog_period_sel)
         2'h0: limit = CYC0;
         2'h1: limit = CYC1;
         2'h2: limit = CYC2;
         2'h3: limit = CYC3;
      endcase
   end

   assign counting = i_wdog_enable_bit && i_alert_on && !i_access;
   assign expire = counting && (r.cnt >= limit - CNT_W'(1));

   always_comb begin
      n = r;
      n.vbus_prev = i_vbus_above;
      n.stage = {r.stage[0], expire};
      if (!counting || expire) begin
         n.cnt = '0;
      end else begin
         n.cnt = r.cnt + CNT_W'(1);
      end
      if (i_role_wr) begin
         n.role = i_role_wdata;
      end
      if (expire) begin
         n.role = `IWD_ROLE_OPEN;
      end
      if (r.stage[0]) begin
         n.discharge = 1'b1;
      end else if (r.discharge && r.vbus_prev && !i_vbus_above) begin
         n.discharge = 1'b0;
      end
      if (i_err_clr) begin
         n.err = 1'b0;
      end
      if (r.stage[1]) begin
         n.err = 1'b1;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         r <= '0;
         r.role <= `IWD_ROLE_RST;
      end else begin
         r <= n;
      end
   end

   assign o_role = r.role;
   assign o_discharge = r.discharge;
   assign o_err = r.err;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_reset);

   sequence open_s;
      o_role == `IWD_ROLE_OPEN;
   endsequence
   sequence drain_s;
      o_discharge;
   endsequence

   wd_disabled_a: assert property (!i_wdog_enable_bit |=> r.cnt == '0)
      else $error("watchdog counted while disabled");
   access_clears_a: assert property (i_access |=> r.cnt == '0)
      else $error("access did not clear watchdog");
   expiry_order_a: assert property (expire |=> open_s ##1 drain_s ##1 o_err)
      else $error("expiry sequence out of order");
   drain_stop_a: assert property (
      o_discharge && !r.stage[0] && r.vbus_prev && !i_vbus_above |=> !o_discharge)
      else $error("discharge not stopped at falling crossing");

endmodule : iwd_wdog

//--- tb/iwd_host.sv
// Purpose: Two-wire host model for the register port.
// Assumes: SDA is pulled up; one bit takes 16 core cycles.
// Notes:   Tasks are called by the testbench.
`timescale 1ns/1ns
module iwd_host (
   // Clock and wire
   input wire logic i_core_clk,
   input wire logic i_sda_wire,
   // Driven pins, 1 = released
   output logic o_scl,
   output logic o_sda_drv
);
   initial begin
      o_scl = 1'b1;
      o_sda_drv = 1'b1;
   end
   task automatic w(input int n);
      repeat (n) @(negedge i_core_clk);
   endtask : w
   // Data moves early in the low phase so a late ACK release settles first
   task automatic bit_io(input logic b, output logic r);
      w(2);
      o_sda_drv = b;
      w(8);
      o_scl = 1'b1;
      w(3);
      r = i_sda_wire;
      w(3);
      o_scl = 1'b0;
   endtask : bit_io
   task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q,
                       output logic r);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], q[i]);
      end
      bit_io(ak, r);
   endtask : xfer
   task automatic start;
      w(2);
      o_sda_drv = 1'b1;
      w(8);
      o_scl = 1'b1;
      w(6);
      o_sda_drv = 1'b0;
      w(6);
      o_scl = 1'b0;
   endtask : start
   task automatic stop;
      w(2);
      o_sda_drv = 1'b0;
      w(8);
      o_scl = 1'b1;
      w(6);
      o_sda_drv = 1'b1;
      w(8);
   endtask : stop
endmodule : iwd_host

//--- tb/testbench.sv
// Purpose: Self-checking bench for the register port and watchdog.
// Assumes: Watchdog periods shortened by parameter.
// Notes:   Host model drives the wire; bench drives the side inputs.
`timescale 1ns/1ns
module testbench;
   localparam int CYC0 = 100;
   localparam int CYC1 = 150;
   localparam int CYC2 = 200;
   localparam int CYC3 = 600;
   logic i_core_clk = 1'b0;
   logic i_reset = 1'b1;
   logic i_enable = 1'b0;
   logic [1:0] i_addr_sel = 2'h0;
   logic [7:0] i_alert_flags = 8'h00;
   logic [7:0] i_alert_mask = 8'h00;
   logic i_wdog_enable_bit = 1'b0;
   logic [1:0] i_wdog_period_sel = 2'h0;
   logic i_role_wr = 1'b0;
   logic [3:0] i_role_wdata = 4'h0;
   logic i_vbus_above_safe0 = 1'b1;
   logic i_host_link_err_clr = 1'b0;
   logic scl, sda_drv, sda_wire, o_sda_out, o_sda_oe, o_alert_n_out, o_alert_n_oe;
   logic o_vbus_discharge, o_host_link_err, o_wr_pulse, o_host_access, a;
   logic [3:0] o_termination_role_ctrl;
   logic [7:0] o_wr_index, o_wr_data, wr_idx, wr_dat, q;
   logic [6:0] dev = 7'h50;
   int mismatches = 0;
   int check_count = 0;
   int wr_seen = 0;
   int acc_seen = 0;
   int lim[3] = '{CYC0, CYC1, CYC2};

   // Open-drain wire with pull-up
   assign sda_wire = sda_drv & (o_sda_oe ? o_sda_out : 1'b1);

   initial begin
      forever #5 i_core_clk = ~i_core_clk;
   end

   iwd_top #(.WD_CYC0(CYC0), .WD_CYC1(CYC1), .WD_CYC2(CYC2), .WD_CYC3(CYC3)) i_iwd_top (
      .i_core_clk(i_core_clk), .i_reset(i_reset), .i_scl(scl), .i_sda(sda_wire),
      .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .i_enable(i_enable),
      .i_addr_sel(i_addr_sel), .i_alert_flags(i_alert_flags),
      .i_alert_mask(i_alert_mask), .o_alert_n_out(o_alert_n_out),
      .o_alert_n_oe(o_alert_n_oe), .i_wdog_enable_bit(i_wdog_enable_bit),
      .i_wdog_period_sel(i_wdog_period_sel), .i_role_wr(i_role_wr),
      .i_role_wdata(i_role_wdata), .o_termination_role_ctrl(o_termination_role_ctrl),
      .i_vbus_above_safe0(i_vbus_above_safe0), .o_vbus_discharge(o_vbus_discharge),
      .o_host_link_err(o_host_link_err), .i_host_link_err_clr(i_host_link_err_clr),
      .o_wr_pulse(o_wr_pulse), .o_wr_index(o_wr_index), .o_wr_data(o_wr_data),
      .o_host_access(o_host_access));

   iwd_host i_iwd_host (.i_core_clk(i_core_clk), .i_sda_wire(sda_wire), .o_scl(scl),
      .o_sda_drv(sda_drv));

   // Pulses are caught mid-cycle, away from the edge that makes them
   always @(negedge i_core_clk) begin
      if (o_wr_pulse === 1'b1) begin
         wr_seen++;
         wr_idx = o_wr_index;
         wr_dat = o_wr_data;
      end
      if (o_host_access === 1'b1) begin
         acc_seen++;
      end
   end

   task automatic w(input int n);
      repeat (n) @(negedge i_core_clk);
   endtask : w
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic close_out;
      $display("Checks %0d, mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : close_out
   task automatic addr(input logic [7:0] b, input logic nak);
      i_iwd_host.start();
      i_iwd_host.xfer(b, 1'b1, q, a);
      chk(a, 8'(nak));
   endtask : addr
   task automatic wr(input logic [7:0] idx, input logic [7:0] d0, input int n);
      addr({dev, 1'b0}, 1'b0);
      i_iwd_host.xfer(idx, 1'b1, q, a);
      chk(a, 8'h00);
      for (int i = 0; i < n; i++) begin
         i_iwd_host.xfer(d0 + 8'(17 * i), 1'b1, q, a);
         chk(a, 8'h00);
         chk(wr_idx, idx + 8'(i));
         chk(wr_dat, d0 + 8'(17 * i));
      end
      i_iwd_host.stop();
   endtask : wr
   task automatic rd(input logic [7:0] idx, input logic [7:0] d0, input int n);
      addr({dev, 1'b0}, 1'b0);
      i_iwd_host.xfer(idx, 1'b1, q, a);
      addr({dev, 1'b1}, 1'b0);
      for (int i = 0; i < n; i++) begin
         i_iwd_host.xfer(8'hFF, i == n - 1, q, a);
         chk(q, d0 + 8'(17 * i));
      end
      i_iwd_host.stop();
   endtask : rd
   task automatic wait_role(output int n);
      n = 0;
      while (o_termination_role_ctrl !== 4'hF && n < 2000) begin
         w(1);
         n++;
      end
      if (n >= 2000) begin
         chk(o_termination_role_ctrl, 8'h0F);
         close_out();
      end
   endtask : wait_role
   task automatic clear_fault;
      i_role_wr = 1'b1;
      i_host_link_err_clr = 1'b1;
      w(1);
      i_role_wr = 1'b0;
      i_host_link_err_clr = 1'b0;
      w(1);
      chk(o_termination_role_ctrl, 8'h00);
      chk(o_host_link_err, 8'h00);
   endtask : clear_fault

   // ------
   // Scenarios
   // ------
   task automatic t_bytes;
      int w0;
      int a0;
      w0 = wr_seen;
      a0 = acc_seen;
      wr(8'h05, 8'hA5, 1);
      chk(8'(wr_seen - w0), 8'h01);
      chk(8'(acc_seen - a0), 8'h01);
      rd(8'h05, 8'hA5, 1);
      wr(8'h10, 8'h3C, 4);
      rd(8'h11, 8'h4D, 2);
      rd(8'h10, 8'h3C, 4);
      $display("Byte and block test done");
   endtask : t_bytes
   task automatic t_refuse;
      int w0;
      w0 = wr_seen;
      addr(8'h00, 1'b1);
      i_iwd_host.xfer(8'h05, 1'b1, q, a);
      chk(a, 8'h01);
      i_iwd_host.stop();
      addr(8'hA2, 1'b1);
      i_iwd_host.stop();
      chk(8'(wr_seen - w0), 8'h00);
      $display("Refusal test done");
   endtask : t_refuse
   task automatic t_wdog;
      int n;
      i_alert_flags = 8'h01;
      i_wdog_enable_bit = 1'b1;
      w(4);
      chk(o_alert_n_oe, 8'h00);
      for (int s = 0; s < 3; s++) begin
         i_wdog_period_sel = 2'(s);
         i_alert_mask = 8'h01;
         w(2);
         chk(o_alert_n_oe, 8'h01);
         chk(o_alert_n_out, 8'h00);
         wait_role(n);
         chk(n + 2 >= lim[s] && n + 2 <= lim[s] + 4, 8'h01);
         w(1);
         chk(o_vbus_discharge, 8'h01);
         chk(o_host_link_err, 8'h00);
         w(1);
         chk(o_host_link_err, 8'h01);
         i_alert_mask = 8'h00;
         i_vbus_above_safe0 = 1'b0;
         w(10);
         chk(o_vbus_discharge, 8'h00);
         i_vbus_above_safe0 = 1'b1;
         w(10);
         chk(o_vbus_discharge, 8'h00);
         clear_fault();
      end
      i_wdog_enable_bit = 1'b0;
      i_alert_mask = 8'h01;
      w(300);
      chk(o_termination_role_ctrl, 8'h00);
      i_wdog_enable_bit = 1'b1;
      i_wdog_period_sel = 2'h3;
      w(400);
      addr({dev, 1'b0}, 1'b0);
      i_iwd_host.stop();
      w(200);
      chk(o_termination_role_ctrl, 8'h00);
      wait_role(n);
      chk(n > 250 && n < 500, 8'h01);
      // Let the fault flag land before clearing it; a set beats the clear
      w(2);
      chk(o_host_link_err, 8'h01);
      i_alert_mask = 8'h00;
      i_wdog_enable_bit = 1'b0;
      clear_fault();
      $display("Watchdog test done");
   endtask : t_wdog
   task automatic t_strap;
      i_enable = 1'b0;
      i_addr_sel = 2'h3;
      w(2);
      i_enable = 1'b1;
      w(2);
      i_addr_sel = 2'h0;
      dev = 7'h53;
      wr(8'h02, 8'h77, 1);
      addr(8'hA0, 1'b1);
      i_iwd_host.stop();
      $display("Address strap test done");
   endtask : t_strap

   initial begin
      w(20);
      i_reset = 1'b0;
      i_enable = 1'b1;
      w(10);
      t_bytes();
      t_refuse();
      t_wdog();
      t_strap();
      close_out();
   end
endmodule : testbench
